// *** fsp_defs.vh ***
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// ==========================================================
// apb register byte offsets and ctrl/status bit positions
`define FSP_REG_FUNC 8'h00
`define FSP_REG_ARG2 8'h04
`define FSP_REG_ARG3 8'h08
`define FSP_REG_ARG4 8'h0C
`define FSP_REG_PTR 8'h10
`define FSP_REG_CTRL 8'h14
`define FSP_REG_RESULT 8'h18
`define FSP_CTRL_GO 0
`define FSP_STAT_BUSY 0
`define FSP_STAT_NMI 1

// ==========================================================
// function codes
`define FSP_FN_ERASE_VFY 4'h3
`define FSP_FN_BYTE_VFY 4'h4
`define FSP_FN_INFO 4'h5
`define FSP_FN_WORD_WR 4'h7
`define FSP_FN_PRE_WR 4'hB
`define FSP_FN_INT_VFY 4'hC
`define FSP_FN_WRITE_BACK 4'hD
`define FSP_FN_AREA_ERASE 4'hE

// ==========================================================
// parameter block word indices and fields
`define FSP_IDX_CTRL 4'h1
`define FSP_IDX_ERASE 4'h2
`define FSP_IDX_WBACK 4'h3
`define FSP_IDX_TIMER 4'h4
`define FSP_IDX_LAST 4'h4
`define FSP_PB_WORDS 12
`define FSP_NMI_BIT 7
`define FSP_WORD_STEP 32'h00000004

// ==========================================================
// completion codes
`define FSP_CC_OK 32'h00000000
`define FSP_CC_REJECT 32'h00000001
`define FSP_CC_FLASH_ERR 32'h00000002

`endif

// *** fsp_param_ram.v ***
`include "fsp_defs.vh"

// local copy of the 48-byte parameter block, registered read
module fsp_param_ram (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // write port
  input wire we,
  input wire [3:0] waddr,
  input wire [31:0] wdata,
  // read port
  input wire [3:0] raddr,
  output reg [31:0] rdata
);

  reg [31:0] mem [0:`FSP_PB_WORDS-1];

  // ==========================================================
  // storage: the array itself needs no reset
  always @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a flop so timing stays short
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// *** fsp_unit_timer.v ***
`include "fsp_defs.vh"

// 16-bit down counter ticking at half the clock, auto reload
module fsp_unit_timer (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // control
  input wire start,
  input wire run,
  input wire [15:0] reload,
  // event
  output reg expire
);

  reg half;
  reg [15:0] cnt;
  reg [15:0] val;

  // ==========================================================
  // each period lasts (reload + 1) ticks of clock / 2
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      half <= 1'b0;
      cnt <= 16'h0000;
      val <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        half <= 1'b0;
        cnt <= reload;
        val <= reload;
      end else if (run) begin
        half <= ~half;
        if (half) begin
          if (cnt == 16'h0000) begin
            expire <= 1'b1;
            cnt <= val;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
      end
    end
  end

endmodule

// *** fsp_dispatcher.v ***
// Design decisions made here: the register addresses and the APB register port.
`include "fsp_defs.vh"

// self-programming command dispatcher with apb slave
module fsp_dispatcher (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // ram master for the parameter block and source data
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  // flash array operation port
  output reg [3:0] flash_op,
  output reg [31:0] flash_addr,
  output reg [31:0] flash_count,
  output reg [31:0] flash_wdata,
  output reg flash_go,
  output wire flash_hv,
  input wire flash_done,
  input wire flash_fail,
  input wire [31:0] flash_info,
  // non-maskable interrupt seen by the cpu
  input wire nmi
);

  localparam S_IDLE = 4'h0;
  localparam S_FETCH = 4'h1;
  localparam S_DISP = 4'h2;
  localparam S_SRC = 4'h3;
  localparam S_GO = 4'h4;
  localparam S_PREP1 = 4'h5;
  localparam S_PREP2 = 4'h6;
  localparam S_PREP3 = 4'h7;
  localparam S_PULSE = 4'h8;
  localparam S_WAIT = 4'h9;
  localparam S_NEXT = 4'hA;
  localparam S_NMIWR = 4'hB;
  localparam S_END = 4'hC;

  reg [3:0] state;
  reg [31:0] func;
  reg [31:0] arg2;
  reg [31:0] arg3;
  reg [31:0] arg4;
  reg [31:0] ptr;
  reg [31:0] completion_code;
  reg nmi_seen;
  reg [3:0] idx;
  reg [31:0] word_no;
  reg [31:0] units;
  reg [31:0] last_area;
  reg [3:0] ram_raddr;
  reg tmr_start;
  reg [15:0] tmr_reload;
  wire [31:0] ram_rdata;
  wire tmr_expire;
  wire busy;
  wire setup_rd;
  wire acc_wr;
  wire mapped;
  wire code_ok;
  wire wr_pulse_op;
  wire timed_op;
  wire [3:0] code;
  wire [15:0] half_word;

  assign busy = (state != S_IDLE);
  assign code = func[3:0];
  // reserved and prohibited codes fall outside this set
  assign code_ok = (func[31:4] == 28'h0000000) &&
    (code == `FSP_FN_ERASE_VFY || code == `FSP_FN_BYTE_VFY ||
     code == `FSP_FN_INFO || code == `FSP_FN_WORD_WR ||
     code == `FSP_FN_PRE_WR || code == `FSP_FN_INT_VFY ||
     code == `FSP_FN_WRITE_BACK || code == `FSP_FN_AREA_ERASE);
  assign wr_pulse_op = (code == `FSP_FN_WORD_WR) ||
    (code == `FSP_FN_PRE_WR);
  assign timed_op = wr_pulse_op || (code == `FSP_FN_AREA_ERASE) ||
    (code == `FSP_FN_WRITE_BACK);
  // low half is the unit timer value, high half the write pulse
  assign half_word = wr_pulse_op ? ram_rdata[31:16] : ram_rdata[15:0];
  assign flash_hv = (state == S_PULSE);

  // ==========================================================
  // apb slave: zero wait states, unmapped offsets flag an error
  assign mapped = (paddr == `FSP_REG_FUNC) || (paddr == `FSP_REG_ARG2) ||
    (paddr == `FSP_REG_ARG3) || (paddr == `FSP_REG_ARG4) ||
    (paddr == `FSP_REG_PTR) || (paddr == `FSP_REG_CTRL) ||
    (paddr == `FSP_REG_RESULT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;

  // read data captured in the setup cycle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      case (paddr)
        `FSP_REG_FUNC: prdata <= func;
        `FSP_REG_ARG2: prdata <= arg2;
        `FSP_REG_ARG3: prdata <= arg3;
        `FSP_REG_ARG4: prdata <= arg4;
        `FSP_REG_PTR: prdata <= ptr;
        `FSP_REG_CTRL: prdata <= {30'h00000000, nmi_seen, busy};
        `FSP_REG_RESULT: prdata <= completion_code;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // argument registers are frozen while a call runs
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      func <= 32'h00000000;
      arg2 <= 32'h00000000;
      arg3 <= 32'h00000000;
      arg4 <= 32'h00000000;
      ptr <= 32'h00000000;
    end else if (acc_wr && !busy) begin
      case (paddr)
        `FSP_REG_FUNC: func <= pwdata;
        `FSP_REG_ARG2: arg2 <= pwdata;
        `FSP_REG_ARG3: arg3 <= pwdata;
        `FSP_REG_ARG4: arg4 <= pwdata;
        `FSP_REG_PTR: ptr <= pwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // parameter block copy and step timer
  always @* begin
    case (state)
      S_PREP1: ram_raddr = (code == `FSP_FN_AREA_ERASE) ?
        `FSP_IDX_ERASE : `FSP_IDX_WBACK;
      S_PREP2: ram_raddr = `FSP_IDX_TIMER;
      default: ram_raddr = `FSP_IDX_CTRL;
    endcase
  end

  fsp_param_ram u_ram (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .we(state == S_FETCH && mem_req && mem_ack),
    .waddr(idx),
    .wdata(mem_rdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  fsp_unit_timer u_tmr (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .run(state == S_PULSE),
    .reload(tmr_reload),
    .expire(tmr_expire)
  );

  // nmi during a call; the start clears it only while idle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_seen <= 1'b0;
    end else if (nmi && busy) begin
      nmi_seen <= 1'b1;
    end else if (acc_wr && !busy && paddr == `FSP_REG_CTRL &&
                 pwdata[`FSP_CTRL_GO]) begin
      nmi_seen <= 1'b0;
    end
  end

  // ==========================================================
  // call sequencer
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      completion_code <= `FSP_CC_OK;
      idx <= 4'h0;
      word_no <= 32'h00000000;
      units <= 32'h00000000;
      last_area <= 32'h00000000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      flash_op <= 4'h0;
      flash_addr <= 32'h00000000;
      flash_count <= 32'h00000000;
      flash_wdata <= 32'h00000000;
      flash_go <= 1'b0;
      tmr_start <= 1'b0;
      tmr_reload <= 16'h0000;
    end else begin
      flash_go <= 1'b0;
      tmr_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (acc_wr && paddr == `FSP_REG_CTRL && pwdata[`FSP_CTRL_GO]) begin
            idx <= `FSP_IDX_CTRL;
            word_no <= 32'h00000000;
            state <= S_FETCH;
          end
        end
        // copy the block words the sequencer uses
        S_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= ptr + {26'h0000000, idx, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            idx <= idx + 4'h1;
            if (idx == `FSP_IDX_LAST) begin
              state <= S_DISP;
            end
          end
        end
        S_DISP: begin
          flash_op <= code;
          flash_count <= arg3;
          if (!code_ok) begin
            completion_code <= `FSP_CC_REJECT;
            state <= S_END;
          end else if (code == `FSP_FN_WORD_WR) begin
            completion_code <= `FSP_CC_OK;
            state <= (arg4 == 32'h00000000) ? S_END : S_SRC;
          end else begin
            if (code != `FSP_FN_WRITE_BACK) begin
              completion_code <= `FSP_CC_OK;
            end
            // 3 and 13 act on the last erased area
            if (code == `FSP_FN_ERASE_VFY ||
                code == `FSP_FN_WRITE_BACK) begin
              flash_addr <= last_area;
            end else begin
              flash_addr <= arg2;
            end
            if (code == `FSP_FN_AREA_ERASE) begin
              last_area <= arg2;
            end
            state <= S_GO;
          end
        end
        // fetch one source word for the word write
        S_SRC: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= arg3 + {word_no[29:0], 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            flash_wdata <= mem_rdata;
            flash_addr <= arg2 + {word_no[29:0], 2'b00};
            flash_count <= `FSP_WORD_STEP;
            state <= S_GO;
          end
        end
        S_GO: begin
          flash_go <= 1'b1;
          state <= timed_op ? S_PREP1 : S_WAIT;
        end
        S_PREP1: begin
          state <= S_PREP2;
        end
        // write pulse is a single period; others count units
        S_PREP2: begin
          units <= wr_pulse_op ? 32'h00000001 : ram_rdata;
          state <= S_PREP3;
        end
        S_PREP3: begin
          tmr_reload <= half_word - 16'h0001;
          tmr_start <= 1'b1;
          state <= (units == 32'h00000000) ? S_WAIT : S_PULSE;
        end
        S_PULSE: begin
          if (tmr_expire) begin
            units <= units - 32'h00000001;
            if (units == 32'h00000001) begin
              state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (flash_done) begin
            if (code == `FSP_FN_INFO) begin
              completion_code <= flash_info;
              state <= S_END;
            end else if (flash_fail && code != `FSP_FN_WRITE_BACK) begin
              completion_code <= `FSP_CC_FLASH_ERR;
              state <= S_END;
            end else begin
              state <= (code == `FSP_FN_WORD_WR) ? S_NEXT : S_END;
            end
          end
        end
        S_NEXT: begin
          word_no <= word_no + 32'h00000001;
          state <= (word_no + 32'h00000001 == arg4) ? S_END : S_SRC;
        end
        // set the nmi flag in the block, never clear it
        S_END: begin
          state <= nmi_seen ? S_NMIWR : S_IDLE;
        end
        S_NMIWR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= ptr + {26'h0000000, `FSP_IDX_CTRL, 2'b00};
            mem_wdata <= ram_rdata | (32'h00000001 << `FSP_NMI_BIT);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// *** fsp_checker.sv ***
// ==========
// protocol checks on the dispatcher ports
module fsp_checker (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // apb
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pslverr,
  // ram port
  input wire mem_req,
  input wire mem_we,
  input wire mem_ack,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  // flash port
  input wire [3:0] flash_op,
  input wire flash_go,
  input wire flash_hv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // apb and dispatch
  property p_unmapped;
    psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without slave error");
  property p_legal_op;
    flash_go |-> flash_op inside {4'h3, 4'h4, 4'h5, 4'h7, 4'hB, 4'hC,
      4'hD, 4'hE};
  endproperty
  a_legal_op: assert property (p_legal_op)
    else $error("flash started with a bad code");
  property p_go_pulse;
    flash_go |=> !flash_go;
  endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("flash start longer than one cycle");
  property p_hv_timed;
    flash_hv |-> flash_op inside {4'h7, 4'hB, 4'hD, 4'hE};
  endproperty
  a_hv_timed: assert property (p_hv_timed)
    else $error("timed pulse on an untimed code");
  // ==========
  // ram traffic
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("ram request changed before ack");
  property p_aligned;
    mem_req |-> mem_addr[1:0] == 2'h0;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("ram access not word aligned");
  property p_nmi_sets;
    mem_req && mem_we |-> mem_wdata[7];
  endproperty
  a_nmi_sets: assert property (p_nmi_sets)
    else $error("control write clears nmi flag");
  property p_quiet_pulse;
    flash_hv |-> !mem_req && !flash_go;
  endproperty
  a_quiet_pulse: assert property (p_quiet_pulse)
    else $error("ram or start during timed pulse");
endmodule

// *** fsp_mem_model.sv ***
// ==========
// caller ram plus flash array stand-in
module fsp_mem_model (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // ram port
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  // flash port
  input wire flash_go,
  input wire flash_hv,
  output logic flash_done,
  output logic flash_fail,
  output logic [31:0] flash_info,
  // behaviour knobs
  input wire slow,
  input wire fail
);
  logic [31:0] mem [0:127];
  int wait_cnt;
  // ram answers after two or five cycles; idle data toggles so it
  // can never be mistaken for a valid read
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_cnt <= 0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_cnt < (slow ? 4 : 1)) begin
      wait_cnt <= wait_cnt + 1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      wait_cnt <= 0;
      if (mem_we) mem[mem_addr[8:2]] <= mem_wdata;
      mem_rdata <= mem[mem_addr[8:2]];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  // flash finishes only once the timed pulse is over; three edges
  // after the start cover the set-up states ahead of the pulse
  initial begin
    flash_done = 1'b0;
    flash_fail = 1'b0;
    flash_info = 32'h5A5A0001;
    forever begin
      @(posedge ref_clk);
      if (flash_go === 1'b1) begin
        repeat (3) @(posedge ref_clk);
        while (flash_hv === 1'b1) @(posedge ref_clk);
        flash_done <= 1'b1;
        flash_fail <= fail;
        @(posedge ref_clk);
        flash_done <= 1'b0;
        flash_fail <= ~fail;
      end
    end
  end
endmodule

// *** tb_flash_self_program_dispatcher.sv ***
// ==========
// self-checking bench for the dispatcher
module tb_flash_self_program_dispatcher;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, psel, penable, pwrite, nmi, slow, fail, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [31:0] flash_addr, flash_count, flash_wdata, flash_info;
  logic pready, pslverr, mem_req, mem_we, mem_ack, flash_go, flash_hv;
  logic flash_done, flash_fail;
  logic [3:0] flash_op;
  int err_total, num_checks, go_total, hv_total;

  fsp_dispatcher uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .flash_op(flash_op),
    .flash_addr(flash_addr),
    .flash_count(flash_count),
    .flash_wdata(flash_wdata),
    .flash_go(flash_go),
    .flash_hv(flash_hv),
    .flash_done(flash_done),
    .flash_fail(flash_fail),
    .flash_info(flash_info),
    .nmi(nmi)
  );
  fsp_mem_model mdl (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .flash_go(flash_go),
    .flash_hv(flash_hv),
    .flash_done(flash_done),
    .flash_fail(flash_fail),
    .flash_info(flash_info),
    .slow(slow),
    .fail(fail)
  );

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // count flash starts and pulse cycles
  always @(posedge ref_clk) begin
    go_total <= go_total + (flash_go === 1'b1);
    hv_total <= hv_total + (flash_hv === 1'b1);
  end
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // parameter block at byte 0x40, words 16 to 27
  task automatic params(input logic [31:0] er, wb);
    mdl.mem[17] = 32'h20;
    mdl.mem[18] = er;
    mdl.mem[19] = wb;
    mdl.mem[20] = {16'h3, 16'h3};
  endtask
  // full call, bounded busy poll, result left in rd
  task automatic call(input logic [31:0] code, a2, a3, a4);
    int n;
    apb(1'b1, 8'h00, code);
    apb(1'b1, 8'h04, a2);
    apb(1'b1, 8'h08, a3);
    apb(1'b1, 8'h0C, a4);
    apb(1'b1, 8'h10, 32'h40);
    // start, then only status reads until the call is over
    apb(1'b1, 8'h14, 32'h1);
    rd = 32'h1;
    for (n = 0; n < 500 && rd[0] !== 1'b0; n++) apb(1'b0, 8'h14, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, serr}, 32'h1);
    check(rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_bad;
    logic [31:0] bad [10] = '{0, 1, 2, 6, 8, 9, 10, 15, 32'h13, 32'h10};
    int g;
    g = go_total;
    foreach (bad[i]) begin
      call(bad[i], 32'h0, 32'h0, 32'h0);
      check(rd, 32'h1);
    end
    check(go_total - g, 32'h0);
    $display("t_bad done");
  endtask
  task automatic t_verify;
    logic [31:0] cd [3] = '{3, 4, 12};
    foreach (cd[i]) begin
      for (int f = 0; f < 2; f++) begin
        fail <= f[0];
        call(cd[i], 32'h200, 32'h10, 32'h0);
        check(rd, f ? 32'h2 : 32'h0);
        if (i > 0) check(flash_addr, 32'h200);
        if (i > 0) check(flash_count, 32'h10);
      end
    end
    fail <= 1'b0;
    call(5, 32'h1, 32'h0, 32'h0);
    check(rd, 32'h5A5A0001);
    $display("t_verify done");
  endtask
  task automatic t_write;
    int h;
    mdl.mem[64] = 32'hA5A50001;
    mdl.mem[65] = 32'h5A5A0002;
    slow <= 1'b1;
    h = hv_total;
    call(7, 32'h1000, 32'h100, 32'h2);
    check(rd, 32'h0);
    // a pulse window is units x 2 x value clocks, plus one start
    // cycle and one stop cycle of the sequencer around it
    check(hv_total - h, 32'd16);
    check(flash_addr, 32'h1004);
    check(flash_wdata, 32'h5A5A0002);
    check(flash_count, 32'h4);
    slow <= 1'b0;
    $display("t_write done");
  endtask
  task automatic t_erase;
    int h;
    h = hv_total;
    fork
      call(14, 32'h2000, 32'h0, 32'h0);
      begin
        repeat (25) @(posedge ref_clk);
        nmi <= 1'b1;
        @(posedge ref_clk);
        nmi <= 1'b0;
      end
    join
    check(rd, 32'h0);
    check({28'h0, flash_op}, 32'hE);
    check(hv_total - h, 32'd14);
    check(mdl.mem[17], 32'hA0);
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h2);
    fail <= 1'b1;
    h = hv_total;
    call(11, 32'h2000, 32'h8, 32'h0);
    check(rd, 32'h2);
    check(hv_total - h, 32'd8);
    h = hv_total;
    call(13, 32'h0, 32'h0, 32'h0);
    check(rd, 32'h2);
    check(hv_total - h, 32'd8);
    check(flash_addr, 32'h2000);
    fail <= 1'b0;
    call(3, 32'h0, 32'h0, 32'h0);
    check(flash_addr, 32'h2000);
    $display("t_erase done");
  endtask
  // ==========
  // main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nmi = 1'b0;
    slow = 1'b0;
    fail = 1'b0;
    err_total = 0;
    num_checks = 0;
    go_total = 0;
    hv_total = 0;
    params(32'h2, 32'h1);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs;
    t_bad;
    t_verify;
    t_write;
    t_erase;
    end_of_test;
  end
  // watchdog well past the thousand or so cycles the tests need
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end
endmodule

bind fsp_dispatcher fsp_checker chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pslverr(pslverr),
  .mem_req(mem_req),
  .mem_we(mem_we),
  .mem_ack(mem_ack),
  .mem_addr(mem_addr),
  .mem_wdata(mem_wdata),
  .flash_op(flash_op),
  .flash_go(flash_go),
  .flash_hv(flash_hv)
);
